// ### logic/spsw_top.sv
// serial pin switch and data inversion for three asynchronous serial channels
// assumes a classic wishbone master on mclk, pins asynchronous to mclk,
// and port logic that supplies the general i/o drive of each shared pin
`timescale 1ns/100ps
`include "spsw_consts.svh"
module spsw_top #(
    parameter int DATA_W = 32,
    parameter int ADR_W = 8
) (
    input wire logic mclk,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [DATA_W/8-1:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // serial channel side
    input wire logic chan1_transmit_out,
    input wire logic infrared_transmit_out,
    input wire logic infrared_mode,
    input wire logic chan2_transmit_out,
    input wire logic chan3_transmit_out,
    output logic chan1_receive_in,
    output logic chan2_receive_in,
    output logic chan3_receive_in,
    // general i/o drive from port logic for each shared transmit pin
    input wire logic port4_bit2_gen_out,
    input wire logic port4_bit2_gen_oe,
    input wire logic portf_bit3_gen_out,
    input wire logic portf_bit3_gen_oe,
    input wire logic port3_bit2_gen_out,
    input wire logic port3_bit2_gen_oe,
    input wire logic porte_bit2_gen_out,
    input wire logic porte_bit2_gen_oe,
    // shared transmit pins, three signals each
    input wire logic port4_bit2_in,
    output logic port4_bit2_out,
    output logic port4_bit2_oe,
    input wire logic portf_bit3_in,
    output logic portf_bit3_out,
    output logic portf_bit3_oe,
    input wire logic port3_bit2_in,
    output logic port3_bit2_out,
    output logic port3_bit2_oe,
    input wire logic porte_bit2_in,
    output logic porte_bit2_out,
    output logic porte_bit2_oe,
    // receive pins
    input wire logic chan1_rx_pin_a,
    input wire logic chan1_rx_pin_b,
    input wire logic chan2_rx_pin,
    input wire logic chan3_rx_pin,
    // synchronised pin levels back to port logic
    output logic [`SPSW_SYNC_W-1:0] pin_level
);

    // ======================================================================
    // elaboration checks
    initial begin
        if (DATA_W < 8 || DATA_W % 8 != 0) begin
            $error("spsw_top: DATA_W must be a multiple of 8, at least 8");
        end
        if (ADR_W < 4 || ADR_W > 8) begin
            $error("spsw_top: ADR_W must be between 4 and 8");
        end
    end

    // ======================================================================
    // helpers

    // pin mux: the switch hands the pin to the serial channel, which always
    // drives, otherwise the port logic keeps its own drive and enable
    function automatic logic [1:0] pin_drive(
        input logic switch_on,
        input logic serial_level,
        input logic gen_out,
        input logic gen_oe
    );
        logic [1:0] res;
        res = {gen_oe, gen_out};
        if (switch_on) begin
            res = {1'b1, serial_level};
        end
        return res;
    endfunction : pin_drive

    // register image: reserved bits forced to one
    function automatic spsw_pkg::spsw_byte_t reg_image(
        input spsw_pkg::spsw_byte_t stored,
        input spsw_pkg::spsw_byte_t wmask,
        input spsw_pkg::spsw_byte_t rsvd
    );
        spsw_pkg::spsw_byte_t res;
        res = (stored & wmask) | rsvd;
        return res;
    endfunction : reg_image

    // ======================================================================
    // pin synchronisers
    logic [`SPSW_SYNC_W-1:0] pin_async;
    logic [`SPSW_SYNC_W-1:0] pin_sync;

    // receive lines idle at mark, so they reset high; tx pins reset low
    localparam logic [`SPSW_SYNC_W-1:0] SYNC_RESET_LEVEL = `SPSW_PIN_RESET;

    assign pin_async = {chan3_rx_pin, chan2_rx_pin, chan1_rx_pin_b, chan1_rx_pin_a,
                        porte_bit2_in, port3_bit2_in, portf_bit3_in, port4_bit2_in};

    spsw_sync #(
        .WIDTH(`SPSW_SYNC_W)
    ) u_sync (
        .mclk(mclk),
        .reset(reset),
        .async_in(pin_async),
        .reset_level(SYNC_RESET_LEVEL),
        .sync_out(pin_sync)
    );

    // ======================================================================
    // wishbone decode
    logic bus_req;
    logic hit_a;
    logic hit_b;
    logic hit_g;
    logic hit_s;
    logic hit_any;
    logic [7:0] adr_byte;
    spsw_pkg::spsw_bus_state_t bus_state_r;
    spsw_pkg::spsw_bus_state_t bus_state_nxt;

    assign bus_req = wb_cyc_i & wb_stb_i;
    assign adr_byte = 8'(wb_adr_i);
    assign hit_a = (adr_byte == `SPSW_OFS_CTRL_A);
    assign hit_b = (adr_byte == `SPSW_OFS_CTRL_B);
    assign hit_g = (adr_byte == `SPSW_OFS_GROUP);
    assign hit_s = (adr_byte == `SPSW_OFS_STATUS);
    assign hit_any = hit_a | hit_b | hit_g | hit_s;

    // a request is seen on one edge and answered on the next; the answer
    // stands one cycle, and a request still held is answered again two cycles later
    always_comb begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            spsw_pkg::SPSW_BUS_IDLE: begin
                if (bus_req) begin
                    bus_state_nxt = spsw_pkg::SPSW_BUS_ANSWER;
                end
            end
            spsw_pkg::SPSW_BUS_ANSWER: begin
                bus_state_nxt = spsw_pkg::SPSW_BUS_IDLE;
            end
            default: begin
                bus_state_nxt = spsw_pkg::SPSW_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            bus_state_r <= spsw_pkg::SPSW_BUS_IDLE;
        end else begin
            bus_state_r <= bus_state_nxt;
        end
    end

    // ack for mapped words, err for anything else
    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= (bus_state_r == spsw_pkg::SPSW_BUS_IDLE) & bus_req & hit_any;
            wb_err_o <= (bus_state_r == spsw_pkg::SPSW_BUS_IDLE) & bus_req & ~hit_any;
        end
    end

    // a write lands on the edge at which the master samples ack
    logic wr_take;

    assign wr_take = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];

    // ======================================================================
    // control registers
    spsw_pkg::spsw_byte_t ctrl_a_r;
    spsw_pkg::spsw_byte_t ctrl_b_r;
    logic group_sel_r;

    // reserved bits never stored, so they cannot be written
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_a_r <= `SPSW_A_RESET;
        end else if (wr_take && hit_a) begin
            ctrl_a_r <= wb_dat_i[7:0] & `SPSW_A_WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            ctrl_b_r <= `SPSW_B_RESET;
        end else if (wr_take && hit_b) begin
            ctrl_b_r <= wb_dat_i[7:0] & `SPSW_B_WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            group_sel_r <= `SPSW_G_RESET;
        end else if (wr_take && hit_g) begin
            group_sel_r <= wb_dat_i[`SPSW_G_CH1_GROUP];
        end
    end

    // ======================================================================
    // read data, captured with the answer
    spsw_pkg::spsw_byte_t rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (hit_a) begin
            rd_byte = reg_image(ctrl_a_r, `SPSW_A_WMASK, `SPSW_A_RSVD);
        end else if (hit_b) begin
            rd_byte = reg_image(ctrl_b_r, `SPSW_B_WMASK, `SPSW_B_RSVD);
        end else if (hit_g) begin
            rd_byte = {7'h00, group_sel_r};
        end else if (hit_s) begin
            rd_byte = pin_sync;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_dat_o <= '0;
        end else if (bus_state_r == spsw_pkg::SPSW_BUS_IDLE && bus_req) begin
            wb_dat_o <= DATA_W'(rd_byte);
        end
    end

    // ======================================================================
    // field aliases
    logic ch1_sw;
    logic ch2_sw;
    logic ch3_sw;
    logic ch1_tx_inv;
    logic ch2_tx_inv;
    logic ch3_tx_inv;
    logic ch1_rx_inv;
    logic ch2_rx_inv;
    logic ch3_rx_inv;

    assign ch1_sw = ctrl_a_r[`SPSW_A_CH1_SW];
    assign ch2_sw = ctrl_a_r[`SPSW_A_CH2_SW];
    assign ch3_sw = ctrl_b_r[`SPSW_B_CH3_SW];
    assign ch1_tx_inv = ctrl_a_r[`SPSW_A_CH1_TXINV];
    assign ch2_tx_inv = ctrl_a_r[`SPSW_A_CH2_TXINV];
    assign ch3_tx_inv = ctrl_b_r[`SPSW_B_CH3_TXINV];
    assign ch1_rx_inv = ctrl_a_r[`SPSW_A_CH1_RXINV];
    assign ch2_rx_inv = ctrl_a_r[`SPSW_A_CH2_RXINV];
    assign ch3_rx_inv = ctrl_b_r[`SPSW_B_CH3_RXINV];

    // ======================================================================
    // transmit path: xor first, then the pin mux, then the output flop.
    // the inversion is not aligned to frames, so a change mid-frame shows
    // on the pin as a glitch; software must change it with the line idle
    logic ch1_tx_level;
    logic ch2_tx_level;
    logic ch3_tx_level;
    logic [1:0] drv_p42;
    logic [1:0] drv_pf3;
    logic [1:0] drv_p32;
    logic [1:0] drv_pe2;

    assign ch1_tx_level = (infrared_mode ? infrared_transmit_out : chan1_transmit_out)
                          ^ ch1_tx_inv;
    assign ch2_tx_level = chan2_transmit_out ^ ch2_tx_inv;
    assign ch3_tx_level = chan3_transmit_out ^ ch3_tx_inv;

    // chan1 goes to one group only; the other group's pin stays general
    assign drv_p42 = pin_drive(ch1_sw & ~group_sel_r, ch1_tx_level,
                               port4_bit2_gen_out, port4_bit2_gen_oe);
    assign drv_pf3 = pin_drive(ch1_sw & group_sel_r, ch1_tx_level,
                               portf_bit3_gen_out, portf_bit3_gen_oe);
    assign drv_p32 = pin_drive(ch2_sw, ch2_tx_level,
                               port3_bit2_gen_out, port3_bit2_gen_oe);
    assign drv_pe2 = pin_drive(ch3_sw, ch3_tx_level,
                               porte_bit2_gen_out, porte_bit2_gen_oe);

    // one flop between mux and pin keeps outputs glitch free at the cost
    // of one mclk of delay, far below any serial bit time
    always_ff @(posedge mclk) begin
        if (reset) begin
            port4_bit2_out <= 1'b0;
            port4_bit2_oe <= 1'b0;
            portf_bit3_out <= 1'b0;
            portf_bit3_oe <= 1'b0;
            port3_bit2_out <= 1'b0;
            port3_bit2_oe <= 1'b0;
            porte_bit2_out <= 1'b0;
            porte_bit2_oe <= 1'b0;
        end else begin
            {port4_bit2_oe, port4_bit2_out} <= drv_p42;
            {portf_bit3_oe, portf_bit3_out} <= drv_pf3;
            {port3_bit2_oe, port3_bit2_out} <= drv_p32;
            {porte_bit2_oe, porte_bit2_out} <= drv_pe2;
        end
    end

    // ======================================================================
    // receive path: synchronised pin, group choice, xor, output flop
    logic ch1_rx_pin;

    assign ch1_rx_pin = group_sel_r ? pin_sync[5] : pin_sync[4];

    always_ff @(posedge mclk) begin
        if (reset) begin
            chan1_receive_in <= 1'b1;
            chan2_receive_in <= 1'b1;
            chan3_receive_in <= 1'b1;
        end else begin
            chan1_receive_in <= ch1_rx_pin ^ ch1_rx_inv;
            chan2_receive_in <= pin_sync[6] ^ ch2_rx_inv;
            chan3_receive_in <= pin_sync[7] ^ ch3_rx_inv;
        end
    end

    // ======================================================================
    // synchronised pin levels for the port data read path
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_level <= SYNC_RESET_LEVEL;
        end else begin
            pin_level <= pin_sync;
        end
    end

endmodule : spsw_top

// ### inc/spsw_consts.svh
// register offsets, field positions and reset values of the serial pin switch
// assumes byte addresses on a wishbone bus with one 32-bit word per register
`ifndef SPSW_CONSTS_SVH
`define SPSW_CONSTS_SVH

// ======================================================================
// register byte offsets
`define SPSW_OFS_CTRL_A 8'h00
`define SPSW_OFS_CTRL_B 8'h04
`define SPSW_OFS_GROUP 8'h08
`define SPSW_OFS_STATUS 8'h0c

// ======================================================================
// serial_pin_control_a fields
`define SPSW_A_CH2_SW 5
`define SPSW_A_CH1_SW 4
`define SPSW_A_CH2_TXINV 3
`define SPSW_A_CH2_RXINV 2
`define SPSW_A_CH1_TXINV 1
`define SPSW_A_CH1_RXINV 0
`define SPSW_A_WMASK 8'h3f
`define SPSW_A_RSVD 8'hc0
`define SPSW_A_RESET 8'h00

// ======================================================================
// serial_pin_control_b fields
`define SPSW_B_CH3_SW 4
`define SPSW_B_CH3_TXINV 1
`define SPSW_B_CH3_RXINV 0
`define SPSW_B_WMASK 8'h13
`define SPSW_B_RSVD 8'hec
`define SPSW_B_RESET 8'h00

// ======================================================================
// pin group select and pin levels
`define SPSW_G_CH1_GROUP 0
`define SPSW_G_RESET 1'b0
`define SPSW_SYNC_W 8
`define SPSW_PIN_RESET 8'hf0

`endif

// ### inc/spsw_pkg.sv
// types shared by the serial pin switch design files
// assumes nothing beyond a systemverilog compiler
package spsw_pkg;

    typedef logic [7:0] spsw_byte_t;

    // bus answer sequencer, one-hot
    typedef enum logic [1:0] {
        SPSW_BUS_IDLE = 2'b01,
        SPSW_BUS_ANSWER = 2'b10
    } spsw_bus_state_t;

endpackage : spsw_pkg

// ### logic/spsw_sync.sv
// two flip-flop synchroniser for levels arriving from pins
// assumes the inputs are asynchronous to mclk and slow against it
`timescale 1ns/100ps
module spsw_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_level,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    initial begin
        if (WIDTH < 1) begin
            $error("spsw_sync: WIDTH must be at least 1");
        end
    end

    // first stage is read only by the second stage
    always_ff @(posedge mclk) begin
        if (reset) begin
            meta_r <= reset_level;
            sync_out <= reset_level;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : spsw_sync

// ### dv/spsw_properties.sv
// assertions on the bus answers and pin paths of spsw_top
// assumes it is bound to spsw_top built with its default widths
`timescale 1ns/100ps
`include "spsw_consts.svh"
module spsw_properties (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic chan1_transmit_out,
    input wire logic infrared_transmit_out,
    input wire logic infrared_mode,
    input wire logic chan2_transmit_out,
    input wire logic chan3_transmit_out,
    input wire logic chan2_receive_in,
    input wire logic chan2_rx_pin,
    input wire logic port4_bit2_out,
    input wire logic port4_bit2_oe,
    input wire logic port3_bit2_out,
    input wire logic port3_bit2_oe,
    input wire logic porte_bit2_out,
    input wire logic porte_bit2_oe
);
    logic [2:0] up_r;
    logic [7:0] a_r, b_r;
    logic g_r, ok, tx1;
    assign ok = up_r == 3'h7;
    assign tx1 = infrared_mode ? infrared_transmit_out : chan1_transmit_out;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // ==========
    // shadow registers; a write lands on the edge that samples ack
    always_ff @(posedge mclk) begin
        if (reset) begin
            a_r <= 8'h00;
            b_r <= 8'h00;
            g_r <= 1'b0;
        end else if (wb_ack_o && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `SPSW_OFS_CTRL_A) a_r <= wb_dat_i[7:0] & `SPSW_A_WMASK;
            if (wb_adr_i == `SPSW_OFS_CTRL_B) b_r <= wb_dat_i[7:0] & `SPSW_B_WMASK;
            if (wb_adr_i == `SPSW_OFS_GROUP) g_r <= wb_dat_i[`SPSW_G_CH1_GROUP];
        end
    end
    // $past is trusted only once reset has been gone for a while
    always_ff @(posedge mclk) begin
        if (reset) up_r <= 3'h0;
        else if (!ok) up_r <= up_r + 3'h1;
    end
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    bus_answer_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o != wb_err_o)
        else $error("request not answered once");
    unmapped_err_a: assert property ($rose(wb_cyc_i && wb_stb_i)
        && wb_adr_i > `SPSW_OFS_STATUS |=> wb_err_o) else $error("unmapped not refused");
    ctrl_a_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `SPSW_OFS_CTRL_A
        |-> wb_dat_o == {24'h0, a_r | `SPSW_A_RSVD}) else $error("control a read wrong");
    ch2_tx_path_a: assert property (ok && $past(a_r[5]) |-> port3_bit2_oe
        && port3_bit2_out == $past(chan2_transmit_out ^ a_r[3])) else $error("chan2 pin wrong");
    ch1_tx_path_a: assert property (ok && $past(a_r[4] && !g_r) |-> port4_bit2_oe
        && port4_bit2_out == $past(tx1 ^ a_r[1])) else $error("chan1 pin wrong");
    ch3_tx_path_a: assert property (ok && $past(b_r[4]) |-> porte_bit2_oe
        && porte_bit2_out == $past(chan3_transmit_out ^ b_r[1])) else $error("chan3 pin wrong");
    ch2_rx_path_a: assert property ((ok && $stable(chan2_rx_pin)) [*4]
        |-> chan2_receive_in == (chan2_rx_pin ^ $past(a_r[2]))) else $error("chan2 rx wrong");
    cover property (wb_err_o);
    cover property (ok && a_r[5] && a_r[3] && port3_bit2_oe);
    cover property (ok && g_r && a_r[4]);
endmodule : spsw_properties

bind spsw_top spsw_properties i_spsw_properties (.*);

// ### dv/spsw_xcvr.sv
// far-side transceivers: echo the transmit pins or drive chosen receive levels
// assumes bit order p42/rx1a, pf3/rx1b, p32/rx2, pe2/rx3 and pulled-up pins
`timescale 1ns/100ps
module spsw_xcvr (
    input wire logic mclk,
    input wire logic loop_en,
    input wire logic [2:0] lag,
    input wire logic [3:0] drive_val,
    input wire logic [3:0] line_in,
    output logic [3:0] rx_line
);
    logic [3:0] dly_r [8];
    always_ff @(posedge mclk) begin
        dly_r[0] <= line_in;
        for (int i = 1; i < 8; i++) begin
            dly_r[i] <= dly_r[i - 1];
        end
    end
    // a slow transceiver echoes lag plus one cycles late
    assign rx_line = loop_en ? dly_r[lag] : drive_val;
endmodule : spsw_xcvr

// ### dv/testbench.sv
// self-checking bench of spsw_top: registers, pin routing, inversion, echo
// assumes spsw_top, spsw_xcvr and the bound checker are compiled with it
`timescale 1ns/100ps
`include "spsw_consts.svh"
module testbench;
    logic mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, grp, loop_en;
    logic [7:0] wb_adr_i, pin_level, ctl_a, ctl_b, v, a;
    logic [7:0] adrs [4];
    logic [3:0] wb_sel_i, rxv, rxl;
    logic [2:0] lag;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic chan1_transmit_out, infrared_transmit_out, infrared_mode, chan2_transmit_out;
    logic chan3_transmit_out, chan1_receive_in, chan2_receive_in, chan3_receive_in;
    logic port4_bit2_gen_out, port4_bit2_gen_oe, portf_bit3_gen_out, portf_bit3_gen_oe;
    logic port3_bit2_gen_out, port3_bit2_gen_oe, porte_bit2_gen_out, porte_bit2_gen_oe;
    logic port4_bit2_out, port4_bit2_oe, portf_bit3_out, portf_bit3_oe;
    logic port3_bit2_out, port3_bit2_oe, porte_bit2_out, porte_bit2_oe;
    logic port4_bit2_in, portf_bit3_in, port3_bit2_in, porte_bit2_in;
    logic chan1_rx_pin_a, chan1_rx_pin_b, chan2_rx_pin, chan3_rx_pin;
    int seed, n_fail, checks_done;
    // released lines float high through their pull-ups
    assign port4_bit2_in = port4_bit2_oe ? port4_bit2_out : 1'b1;
    assign portf_bit3_in = portf_bit3_oe ? portf_bit3_out : 1'b1;
    assign port3_bit2_in = port3_bit2_oe ? port3_bit2_out : 1'b1;
    assign porte_bit2_in = porte_bit2_oe ? porte_bit2_out : 1'b1;
    assign {chan3_rx_pin, chan2_rx_pin, chan1_rx_pin_b, chan1_rx_pin_a} = rxl;
    spsw_top i_spsw_top (.*);
    spsw_xcvr i_spsw_xcvr (.mclk(mclk), .loop_en(loop_en), .lag(lag), .drive_val(rxv),
        .line_in({porte_bit2_in, port3_bit2_in, portf_bit3_in, port4_bit2_in}), .rx_line(rxl));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ==========
    // checking and closing
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk_bus(input string what, input logic [32:0] e, input logic [32:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk_bus
    task automatic chk_pins(input string what, input logic [18:0] e, input logic [18:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk_pins
    function automatic logic [32:0] exp_read(input logic [7:0] ad);
        logic [18:0] e;
        e = expect_pins();
        case (ad)
            `SPSW_OFS_STATUS: return {25'h0, e[18:11]};
            `SPSW_OFS_CTRL_A: return {25'h0, ctl_a | `SPSW_A_RSVD};
            `SPSW_OFS_CTRL_B: return {25'h0, ctl_b | `SPSW_B_RSVD};
            `SPSW_OFS_GROUP: return {32'h0, grp};
            default: return {1'b1, 32'h0};
        endcase
    endfunction : exp_read
    // {synced pin levels, rx3, rx2, rx1, then oe and out of pe2, p32, pf3, p42}
    function automatic logic [18:0] expect_pins();
        logic [7:0] p;
        logic [3:0] lv, ln;
        logic t1, t2, t3;
        t1 = (infrared_mode ? infrared_transmit_out : chan1_transmit_out) ^ ctl_a[1];
        t2 = chan2_transmit_out ^ ctl_a[3];
        t3 = chan3_transmit_out ^ ctl_b[1];
        p[1:0] = ctl_a[4] && !grp ? {1'b1, t1} : {port4_bit2_gen_oe, port4_bit2_gen_out};
        p[3:2] = ctl_a[4] && grp ? {1'b1, t1} : {portf_bit3_gen_oe, portf_bit3_gen_out};
        p[5:4] = ctl_a[5] ? {1'b1, t2} : {port3_bit2_gen_oe, port3_bit2_gen_out};
        p[7:6] = ctl_b[4] ? {1'b1, t3} : {porte_bit2_gen_oe, porte_bit2_gen_out};
        for (int k = 0; k < 4; k++) lv[k] = p[2 * k + 1] ? p[2 * k] : 1'b1;
        ln = loop_en ? lv : rxv;
        return {ln, lv, ln[3] ^ ctl_b[0], ln[2] ^ ctl_a[2], (grp ? ln[1] : ln[0]) ^ ctl_a[0], p};
    endfunction : expect_pins
    // ==========
    // stimulus
    task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] d,
                       input logic s, output logic [32:0] q);
        int n;
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, w, ad};
        wb_sel_i <= {3'h7, s};
        wb_dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!wb_ack_o && !wb_err_o && n < 20);
        q = {wb_err_o, wb_dat_o};
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (!wb_ack_o && !wb_err_o) begin
            n_fail++;
            $display("[FAIL] bus answer expected ack seen none");
            close_out();
        end
    endtask : bus
    task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic s);
        logic [32:0] q;
        bus(1'b1, ad, d, s, q);
        if (s && ad == `SPSW_OFS_CTRL_A) ctl_a = d & `SPSW_A_WMASK;
        if (s && ad == `SPSW_OFS_CTRL_B) ctl_b = d & `SPSW_B_WMASK;
        if (s && ad == `SPSW_OFS_GROUP) grp = d[`SPSW_G_CH1_GROUP];
    endtask : wr
    task automatic rd(input logic [7:0] ad);
        logic [32:0] q;
        bus(1'b0, ad, 8'h00, 1'b1, q);
        chk_bus("register read", exp_read(ad), q);
    endtask : rd
    task automatic stir();
        logic [31:0] r;
        r = $random(seed);
        {chan1_transmit_out, infrared_transmit_out, infrared_mode} <= r[2:0];
        {chan2_transmit_out, chan3_transmit_out, rxv, loop_en} <= r[9:3];
        {port4_bit2_gen_out, port4_bit2_gen_oe, portf_bit3_gen_out, portf_bit3_gen_oe} <= r[13:10];
        {port3_bit2_gen_out, port3_bit2_gen_oe, porte_bit2_gen_out, porte_bit2_gen_oe} <= r[17:14];
        lag <= r[18] ? 3'h6 : 3'h1;
    endtask : stir
    task automatic look();
        repeat (14) @(posedge mclk);
        chk_pins("pins", expect_pins(), {pin_level, chan3_receive_in, chan2_receive_in,
            chan1_receive_in, porte_bit2_oe, porte_bit2_out, port3_bit2_oe, port3_bit2_out,
            portf_bit3_oe, portf_bit3_out, port4_bit2_oe, port4_bit2_out});
        rd(`SPSW_OFS_STATUS);
    endtask : look
    initial begin
        seed = 32'h731a;
        {n_fail, checks_done} = '0;
        {reset, ctl_a, ctl_b, grp} = {1'b1, 17'h0};
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        adrs = '{`SPSW_OFS_CTRL_A, `SPSW_OFS_CTRL_B, `SPSW_OFS_GROUP, 8'h40};
        stir();
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) rd(adrs[i]);
        wr(`SPSW_OFS_CTRL_A, 8'hff, 1'b0);
        wr(8'h40, 8'hff, 1'b1);
        rd(`SPSW_OFS_CTRL_A);
        $display("test reset and refusals done");
        for (int i = 0; i < 12; i++) begin
            a = adrs[$unsigned($random(seed)) % 4];
            wr(a, 8'($random(seed)), 1'b1);
            rd(a);
        end
        $display("test register access done");
        for (int i = 0; i < 30; i++) begin
            v = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed));
            wr(`SPSW_OFS_CTRL_A, v, 1'b1);
            wr(`SPSW_OFS_CTRL_B, i < 2 ? v : 8'($random(seed)), 1'b1);
            wr(`SPSW_OFS_GROUP, {7'h0, v[7] ^ i[0]}, 1'b1);
            @(posedge mclk);
            stir();
            look();
            wr(`SPSW_OFS_CTRL_A, ctl_a ^ 8'h0f, 1'b1);
            look();
        end
        $display("test routing and inversion done");
        @(posedge mclk);
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        {ctl_a, ctl_b, grp} = '0;
        rd(`SPSW_OFS_CTRL_B);
        look();
        $display("test second reset done");
        close_out();
    end
endmodule : testbench
